/* File: rtl/status_reporting_and_service_request.sv */
// Behaviour
// RQ1: Remote entered only when listen-addressed with enable
// RQ2: Remote blocks keys except local; exit restores
// RQ3: Talk address sets talker; untalk/listen/clear reset
// RQ4: Listen address sets listener; unlisten/talk/clear reset
// RQ5: Request indicator holds until poll or causes gone
// RQ6: Local key cancels remote, restores display
// RQ7: Lockout disables local key until go-to-local
// RQ8: Four register sets feed status byte summaries
// RQ9: Condition registers read-only, track live inputs
// RQ10: Event bits latch from conditions until cleared
// RQ11: Masked events OR into one summary bit
// RQ12: Event read, power-up, clear-status clear events
// RQ13: Enable read harmless; power-up or zero clears
// RQ14: Preset clears three enables, keeps standard enable
// RQ15: Output queue FIFO drives message available bit
// RQ16: Controller queries then talk-addresses to drain
// RQ17: Error queue FIFO holds ten, read removes
// RQ18: Error available follows error queue non-empty
// RQ19: Status byte and request mask are eight bits
// RQ20: Status byte bit positions fixed, bit one zero
// RQ21: Summary bits follow sources without latching
// RQ22: Masked summaries gate bit six
// RQ23: Enabled rise sets request; poll clears request only
// RQ24: Power-up and clear-status clear status byte; clear-status keeps the message available bit while the output queue holds data
`timescale 1ns/10ps
`include "status_defines.svh"
module status_reporting_and_service_request
  import status_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Bus lines and decoded bus commands
  input wire logic ren_in,
  input wire logic my_talk_addr_in,
  input wire logic my_listen_addr_in,
  input wire logic untalk_in,
  input wire logic unlisten_in,
  input wire logic ifc_in,
  input wire logic llo_in,
  input wire logic gtl_in,
  input wire logic serial_poll_in,
  // Front panel
  input wire logic local_key_in,
  input wire logic [7:0] panel_keys_in,
  output logic [7:0] panel_keys_out,
  output logic display_restore_out,
  // Indicators
  output logic remote_indicator_out,
  output logic talk_indicator_out,
  output logic listener_active_indicator_out,
  output logic srq_indicator_out,
  output logic srq_out,
  // Live conditions
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] ques_cond_in,
  input wire logic [15:0] meas_cond_in,
  input wire logic [15:0] std_cond_in,
  // Common commands
  input wire logic clear_status_in,
  input wire logic status_preset_in,
  // Queue fill
  input wire logic oq_push_in,
  input wire logic [7:0] oq_data_in,
  output logic oq_full_out,
  input wire logic eq_push_in,
  input wire logic [15:0] eq_data_in,
  // Register access
  input wire logic [3:0] reg_sel_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic ren_meta, ren_sync;
  logic key_meta, key_sync, key_prev;
  logic [7:0] keys_meta, keys_sync;

  // Two flops on every asynchronous pin
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ren_meta <= 1'b0;
      ren_sync <= 1'b0;
      key_meta <= 1'b0;
      key_sync <= 1'b0;
      key_prev <= 1'b0;
      keys_meta <= `BYTE_RST;
      keys_sync <= `BYTE_RST;
    end else begin
      ren_meta <= ren_in;
      ren_sync <= ren_meta;
      key_meta <= local_key_in;
      key_sync <= key_meta;
      key_prev <= key_sync;
      keys_meta <= panel_keys_in;
      keys_sync <= keys_meta;
    end
  end

  // ------------------------------------------------------------
  // Remote, lockout, talker and listener
  // ------------------------------------------------------------
  logic remote, lockout, talker, listener;
  wire key_press = key_sync && !key_prev;
  wire local_accept = key_press && remote && !lockout; // RQ7
  wire go_remote = ren_sync && my_listen_addr_in; // RQ1
  wire go_local = !ren_sync || gtl_in || local_accept; // RQ6

  // Remote and lockout state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      remote <= 1'b0;
      lockout <= 1'b0;
      display_restore_out <= 1'b0;
    end else begin
      if (go_local) begin
        remote <= 1'b0; // RQ6
      end else if (go_remote) begin
        remote <= 1'b1; // RQ1
      end
      if (!ren_sync || gtl_in) begin
        lockout <= 1'b0; // RQ7
      end else if (llo_in) begin
        lockout <= 1'b1; // RQ7
      end
      display_restore_out <= local_accept; // RQ6
    end
  end

  // Talker and listener addressing
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || ifc_in) begin
      talker <= 1'b0;
      listener <= 1'b0;
    end else begin
      if (my_talk_addr_in) begin
        talker <= 1'b1; // RQ3
      end else if (untalk_in || my_listen_addr_in) begin
        talker <= 1'b0; // RQ3
      end
      if (my_listen_addr_in) begin
        listener <= 1'b1; // RQ4
      end else if (unlisten_in || my_talk_addr_in) begin
        listener <= 1'b0; // RQ4
      end
    end
  end

  // Keys pass only in local
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      panel_keys_out <= `BYTE_RST;
    end else begin
      panel_keys_out <= remote ? `BYTE_RST : keys_sync; // RQ2
    end
  end

  assign remote_indicator_out = remote; // RQ2
  assign talk_indicator_out = talker;
  assign listener_active_indicator_out = listener;

  // ------------------------------------------------------------
  // Register sets
  // ------------------------------------------------------------
  set_word_t cond [`SET_CNT];
  set_word_t cond_prev [`SET_CNT];
  set_word_t evt [`SET_CNT];
  set_word_t en [`SET_CNT];
  logic [`SET_CNT-1:0] summary;
  wire [1:0] set_idx = reg_sel_in[1:0];
  wire sel_cond = (reg_sel_in[3:2] == 2'b00);
  wire sel_evt = (reg_sel_in[3:2] == 2'b01);
  wire sel_en = (reg_sel_in[3:2] == 2'b10);

  // Live conditions, no writes possible
  assign cond[`SET_OPER] = oper_cond_in; // RQ9
  assign cond[`SET_QUES] = ques_cond_in;
  assign cond[`SET_MEAS] = meas_cond_in;
  assign cond[`SET_STD] = std_cond_in & `STD_EN_MASK;

  // Event latch, enable storage per set
  for (genvar s = 0; s < `SET_CNT; s++) begin : g_set
    wire evt_clr = clear_status_in || (reg_rd_in && sel_evt && set_idx == 2'(s)); // RQ12
    wire en_wr = reg_wr_in && sel_en && set_idx == 2'(s);
    wire [15:0] wmask = (s == `SET_STD) ? `STD_EN_MASK : 16'hffff;
    wire [15:0] evt_set = cond[s] & ~cond_prev[s];

    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        cond_prev[s] <= `SET_RST;
        evt[s] <= `SET_RST; // RQ12
        en[s] <= `SET_RST; // RQ13
      end else begin
        cond_prev[s] <= cond[s];
        // Set wins over clear
        evt[s] <= (evt_clr ? `SET_RST : evt[s]) | evt_set; // RQ10
        if (en_wr) begin
          en[s] <= reg_wdata_in & wmask; // RQ13
        end else if (status_preset_in && s != `SET_STD) begin
          en[s] <= `SET_RST; // RQ14
        end
      end
    end

    assign summary[s] = |(evt[s] & en[s]); // RQ11 RQ8
  end

  // ------------------------------------------------------------
  // Queues
  // ------------------------------------------------------------
  logic [7:0] oq_rdata;
  logic [15:0] eq_rdata;
  logic oq_empty, eq_empty;
  wire oq_pop = reg_rd_in && reg_sel_in == SEL_OUTQ && talker; // RQ16
  wire eq_pop = reg_rd_in && reg_sel_in == SEL_ERRQ;

  // Response queue
  status_fifo #(.WIDTH(`BYTE_W), .DEPTH(`OQ_DEPTH), .AW(`OQ_AW)) u_outq (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .flush_in(1'b0),
    .push_in(oq_push_in),
    .push_data_in(oq_data_in),
    .pop_in(oq_pop), // RQ15
    .pop_data_out(oq_rdata),
    .empty_out(oq_empty),
    .full_out(oq_full_out)
  );

  // Error queue, ten entries
  status_fifo #(.WIDTH(`SET_W), .DEPTH(`EQ_DEPTH), .AW(`EQ_AW)) u_errq (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .flush_in(clear_status_in),
    .push_in(eq_push_in),
    .push_data_in(eq_data_in),
    .pop_in(eq_pop), // RQ17
    .pop_data_out(eq_rdata),
    .empty_out(eq_empty),
    .full_out()
  );

  // ------------------------------------------------------------
  // Status byte and service request
  // ------------------------------------------------------------
  logic [7:0] sre;
  logic [7:0] summ_prev;
  logic rqs;
  logic [7:0] summ_byte;
  wire [7:0] enabled_summ;
  wire mss;
  wire rqs_rise;

  // Non-latching summary byte
  always_comb begin
    summ_byte = `BYTE_RST;
    summ_byte[`SB_MEAS] = summary[`SET_MEAS]; // RQ20 RQ21
    summ_byte[`SB_EAV] = !eq_empty; // RQ18
    summ_byte[`SB_QUES] = summary[`SET_QUES];
    summ_byte[`SB_MAV] = !oq_empty; // RQ15
    summ_byte[`SB_ESB] = summary[`SET_STD];
    summ_byte[`SB_OPER] = summary[`SET_OPER];
  end

  assign enabled_summ = summ_byte & sre; // RQ22
  assign mss = |enabled_summ; // RQ22
  assign rqs_rise = |(enabled_summ & ~summ_prev); // RQ23

  // Mask register and request latch
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sre <= `BYTE_RST; // RQ13
      summ_prev <= `BYTE_RST;
      rqs <= 1'b0; // RQ24
    end else begin
      if (reg_wr_in && reg_sel_in == SEL_SRE) begin
        sre <= reg_wdata_in[7:0] & ~(8'h01 << `SB_RQS); // RQ19
      end
      summ_prev <= enabled_summ;
      if (rqs_rise) begin
        rqs <= 1'b1; // RQ23
      end else if (serial_poll_in || !mss || clear_status_in) begin
        rqs <= 1'b0; // RQ5 RQ24
      end
    end
  end

  assign srq_out = rqs; // RQ23
  assign srq_indicator_out = rqs; // RQ5

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [15:0] rd_hold;
  logic rd_queue, rd_errq;
  logic [15:0] rd_mux;

  // Select register read value
  always_comb begin
    rd_mux = `SET_RST;
    if (sel_cond) begin
      rd_mux = cond[set_idx];
    end else if (sel_evt) begin
      rd_mux = evt[set_idx];
    end else if (sel_en) begin
      rd_mux = en[set_idx];
    end else if (reg_sel_in == SEL_STB) begin
      rd_mux = {8'h00, summ_byte | (8'(mss) << `SB_RQS)};
    end else if (reg_sel_in == SEL_SRE) begin
      rd_mux = {8'h00, sre};
    end
  end

  // Capture read data one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_hold <= `SET_RST;
      rd_queue <= 1'b0;
      rd_errq <= 1'b0;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      rd_queue <= oq_pop || eq_pop;
      rd_errq <= eq_pop;
      if (reg_rd_in) begin
        rd_hold <= rd_mux;
      end
    end
  end

  assign reg_rdata_out = !rd_queue ? rd_hold : rd_errq ? eq_rdata : {8'h00, oq_rdata};
endmodule

/* File: rtl/status_defines.svh */
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH
// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define SET_W 16
`define SET_CNT 4
`define BYTE_W 8
`define OQ_DEPTH 16
`define OQ_AW 4
`define EQ_DEPTH 10
`define EQ_AW 4
// ----------------------------------------------------------------
// Register set indices
// ----------------------------------------------------------------
`define SET_OPER 0
`define SET_QUES 1
`define SET_MEAS 2
`define SET_STD 3
// ----------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------
`define SB_MEAS 0
`define SB_SPARE 1
`define SB_EAV 2
`define SB_QUES 3
`define SB_MAV 4
`define SB_ESB 5
`define SB_RQS 6
`define SB_OPER 7
// Operation condition measuring bit
`define OPER_MEASURING 4
// ----------------------------------------------------------------
// Reset values and standard enable mask
// ----------------------------------------------------------------
`define SET_RST 16'h0000
`define BYTE_RST 8'h00
`define STD_EN_MASK 16'h00ff
`endif

/* File: rtl/status_pkg.sv */
package status_pkg;
  // Register selector for the internal access port
  typedef enum logic [3:0] {
    SEL_COND0 = 4'h0,
    SEL_COND1 = 4'h1,
    SEL_COND2 = 4'h2,
    SEL_COND3 = 4'h3,
    SEL_EVT0 = 4'h4,
    SEL_EVT1 = 4'h5,
    SEL_EVT2 = 4'h6,
    SEL_EVT3 = 4'h7,
    SEL_EN0 = 4'h8,
    SEL_EN1 = 4'h9,
    SEL_EN2 = 4'ha,
    SEL_EN3 = 4'hb,
    SEL_STB = 4'hc,
    SEL_SRE = 4'hd,
    SEL_OUTQ = 4'he,
    SEL_ERRQ = 4'hf
  } reg_sel_e;
  // One status register set word
  typedef logic [15:0] set_word_t;
endpackage

/* File: rtl/status_fifo.sv */
`timescale 1ns/10ps
`include "status_defines.svh"
// ------------------------------------------------------------
// Small FIFO with registered read data
// ------------------------------------------------------------
module status_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic flush_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  // Status and data
  output logic [WIDTH-1:0] pop_data_out,
  output logic empty_out,
  output logic full_out
);
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_push;
  wire do_pop;

  // Wrap an index at the depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign empty_out = (count == '0);
  assign full_out = (count == (AW+1)'(DEPTH));
  // Pushes when full are dropped, pops when empty ignored
  assign do_push = push_in && !full_out && !flush_in;
  assign do_pop = pop_in && !empty_out && !flush_in;

  // Memory write and registered read
  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
    if (rst_in) begin
      pop_data_out <= '0;
    end else if (do_pop) begin
      pop_data_out <= mem[rd_ptr];
    end
  end

  // Pointers and fill count
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (do_pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

/* File: verif/status_reporting_and_service_request_props.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module status_reporting_and_service_request_props (
  // Clock, reset, bus commands and register access
  input wire logic sys_clk_in, rst_in, my_talk_addr_in, my_listen_addr_in,
  input wire logic untalk_in, unlisten_in, ifc_in, serial_poll_in, reg_rd_in,
  input wire logic [3:0] reg_sel_in,
  // Observed outputs
  input logic [7:0] panel_keys_out,
  input logic remote_indicator_out, talk_indicator_out, srq_out,
  input logic listener_active_indicator_out, srq_indicator_out, reg_rvalid_out,
  input logic [15:0] reg_rdata_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Own talk address without clear
  sequence talk_cmd;
    my_talk_addr_in && !ifc_in;
  endsequence
  // Own listen address without clear
  sequence listen_cmd;
    my_listen_addr_in && !ifc_in;
  endsequence
  a_talk_on: assert property (talk_cmd |=> talk_indicator_out)
    else $error("talker not set");
  a_talk_idle: assert property (untalk_in || ifc_in || my_listen_addr_in |=>
    !talk_indicator_out) else $error("talker not idle");
  a_listen_on: assert property (listen_cmd |=> listener_active_indicator_out)
    else $error("listener not set");
  a_listen_idle: assert property (unlisten_in || ifc_in || my_talk_addr_in |=>
    !listener_active_indicator_out) else $error("listener not idle");
  a_poll_drops: assert property (serial_poll_in |=> !srq_out)
    else $error("request kept after poll");
  a_srq_lamp: assert property (srq_indicator_out == srq_out)
    else $error("request lamp differs");
  a_keys_locked: assert property (remote_indicator_out && $past(remote_indicator_out)
    |-> panel_keys_out == 8'h00) else $error("keys live in remote");
  a_read_answer: assert property (reg_rvalid_out == $past(reg_rd_in))
    else $error("read answer timing");
  a_stb_spare: assert property (reg_rvalid_out && $past(reg_sel_in) == 4'hc
    |-> reg_rdata_out[15:8] == 8'h00 && !reg_rdata_out[1]) else $error("spare bits set");
endmodule
bind status_reporting_and_service_request status_reporting_and_service_request_props props_i (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .my_talk_addr_in(my_talk_addr_in),
  .my_listen_addr_in(my_listen_addr_in), .untalk_in(untalk_in), .unlisten_in(unlisten_in),
  .ifc_in(ifc_in), .serial_poll_in(serial_poll_in), .reg_rd_in(reg_rd_in),
  .reg_sel_in(reg_sel_in), .panel_keys_out(panel_keys_out), .srq_out(srq_out),
  .remote_indicator_out(remote_indicator_out), .talk_indicator_out(talk_indicator_out),
  .listener_active_indicator_out(listener_active_indicator_out),
  .srq_indicator_out(srq_indicator_out), .reg_rvalid_out(reg_rvalid_out),
  .reg_rdata_out(reg_rdata_out));

/* File: verif/bus_ctl_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Bus controller model
// ----------------------------------------
module bus_ctl_model (
  // Clock
  input wire logic sys_clk_in,
  // Bus lines: talk, listen, untalk, unlisten, clear, lockout, local, poll
  output logic ren_out,
  output logic [7:0] cmd_out
);
  initial begin
    ren_out = 1'b0;
    cmd_out = 8'h00;
  end
  // One-cycle decoded command, launched off the sampling edge
  task automatic send(input int k);
    @(negedge sys_clk_in) cmd_out[k] = 1'b1;
    @(negedge sys_clk_in) cmd_out = 8'h00;
  endtask
  // Remote-enable line level
  task automatic set_ren(input logic v);
    @(negedge sys_clk_in) ren_out = v;
  endtask
endmodule

/* File: verif/test_status_reporting_and_service_request.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Testbench
// ----------------------------------------
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module test_status_reporting_and_service_request;
  logic clk, rst, key, cs, sp, oqp, eqp, rd, wr, seen;
  logic ren, remote_indicator, talk, lsn, srqi, srq, rv, rest, oqf;
  logic [7:0] cmd, keys, keys_o, oqd;
  logic [15:0] oc, qc, mc, sc, eqd, wd, rdat;
  logic [3:0] sel;
  int miscompares = 0, n_checks = 0;
  bus_ctl_model ctl (.sys_clk_in(clk), .ren_out(ren), .cmd_out(cmd));
  status_reporting_and_service_request dut (.sys_clk_in(clk), .rst_in(rst), .ren_in(ren),
    .my_talk_addr_in(cmd[0]), .my_listen_addr_in(cmd[1]), .untalk_in(cmd[2]),
    .unlisten_in(cmd[3]), .ifc_in(cmd[4]), .llo_in(cmd[5]), .gtl_in(cmd[6]),
    .serial_poll_in(cmd[7]), .local_key_in(key), .panel_keys_in(keys),
    .panel_keys_out(keys_o), .display_restore_out(rest), .remote_indicator_out(remote_indicator),
    .talk_indicator_out(talk), .listener_active_indicator_out(lsn),
    .srq_indicator_out(srqi), .srq_out(srq), .oper_cond_in(oc), .ques_cond_in(qc),
    .meas_cond_in(mc), .std_cond_in(sc), .clear_status_in(cs), .status_preset_in(sp),
    .oq_push_in(oqp), .oq_data_in(oqd), .oq_full_out(oqf), .eq_push_in(eqp),
    .eq_data_in(eqd), .reg_sel_in(sel), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Register read with expected value
  task automatic rd_chk(input logic [3:0] s, input logic [15:0] e);
    @(negedge clk) begin sel = s; rd = 1; end
    @(negedge clk) rd = 0;
    `CHK(rv, 1'b1)
    `CHK(rdat, e)
  endtask
  task automatic wr_reg(input logic [3:0] s, input logic [15:0] v);
    @(negedge clk) begin sel = s; wd = v; wr = 1; end
    @(negedge clk) wr = 0;
  endtask
  // Local key press, watching the restore pulse
  task automatic press();
    seen = 0;
    @(negedge clk) key = 1;
    repeat (8) @(negedge clk) seen |= rest;
    key = 0;
  endtask
  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  // Main sequence
  initial begin
    // Idle levels before the first edge
    rst = 1'b1;
    {key, cs, sp, oqp, eqp, rd, wr} = 7'h00;
    keys = 8'h00;
    oqd = 8'h00;
    {oc, qc, mc, sc} = 64'h0;
    {eqd, wd} = 32'h0;
    sel = 4'h0;
    tick(10); rst = 0; tick(1);
    `CHK(remote_indicator, 1'b0)
    ctl.set_ren(1); tick(5); `CHK(remote_indicator, 1'b0)
    ctl.send(1); tick(2); `CHK(remote_indicator, 1'b1)
    `CHK(lsn, 1'b1)
    keys = 8'h5a; tick(5); `CHK(keys_o, 8'h00)
    ctl.send(5); press(); `CHK(remote_indicator, 1'b1)
    ctl.send(6); tick(5); `CHK(remote_indicator, 1'b0)
    `CHK(keys_o, 8'h5a)
    ctl.set_ren(0); tick(4); ctl.set_ren(1); tick(4); ctl.send(1); tick(2);
    press(); `CHK(seen, 1'b1)
    `CHK(remote_indicator, 1'b0)
    ctl.send(0); tick(1); `CHK(talk, 1'b1)
    `CHK(lsn, 1'b0)
    ctl.send(4); tick(1); `CHK(talk, 1'b0)
    ctl.send(1); ctl.send(3); tick(1); `CHK(lsn, 1'b0)
    ctl.send(0); ctl.send(2); tick(1); `CHK(talk, 1'b0)
    // Condition, event and summary path
    wr_reg(4'h8, 16'h0010); wr_reg(4'hd, 16'h00c0);
    rd_chk(4'hd, 16'h0080);
    oc = 16'h0010; tick(3); rd_chk(4'h0, 16'h0010);
    oc = 16'h0000; tick(3); rd_chk(4'h0, 16'h0000);
    `CHK(srq, 1'b1)
    `CHK(srqi, 1'b1)
    rd_chk(4'hc, 16'h00c0);
    ctl.send(7); tick(1); `CHK(srq, 1'b0)
    rd_chk(4'hc, 16'h00c0);
    rd_chk(4'h8, 16'h0010);
    rd_chk(4'h4, 16'h0010);
    rd_chk(4'h4, 16'h0000);
    rd_chk(4'hc, 16'h0000);
    // Preset and standard enable
    wr_reg(4'hb, 16'h00ff); @(negedge clk) sp = 1; @(negedge clk) sp = 0;
    rd_chk(4'h8, 16'h0000);
    rd_chk(4'hb, 16'h00ff);
    wr_reg(4'hb, 16'h0000); rd_chk(4'hb, 16'h0000);
    // Questionable and measurement sets, one event masked
    wr_reg(4'h9, 16'h0001); wr_reg(4'ha, 16'h0002);
    qc = 16'h0001; mc = 16'h0001; tick(3);
    rd_chk(4'hc, 16'h0008);
    mc = 16'h0003; tick(3);
    rd_chk(4'hc, 16'h0009);
    rd_chk(4'h1, 16'h0001);
    rd_chk(4'h2, 16'h0003);
    rd_chk(4'ha, 16'h0002);
    rd_chk(4'h5, 16'h0001);
    rd_chk(4'h6, 16'h0003);
    rd_chk(4'hc, 16'h0000);
    // Output queue filled to its depth, then drained
    for (int i = 0; i < 16; i++) begin
      @(negedge clk) begin oqp = 1; oqd = 8'h30 + i[7:0]; end
    end
    @(negedge clk) oqp = 0;
    tick(1);
    `CHK(oqf, 1'b1)
    rd_chk(4'hc, 16'h0010);
    ctl.send(0);
    for (int i = 0; i < 16; i++) rd_chk(4'he, 16'h0030 + i[15:0]);
    `CHK(oqf, 1'b0)
    tick(1); rd_chk(4'hc, 16'h0000);
    // Error queue: eleven pushed, ten kept
    for (int i = 0; i < 11; i++) begin
      @(negedge clk) begin eqp = 1; eqd = 16'h0100 + i[15:0]; end
    end
    @(negedge clk) eqp = 0;
    tick(1); rd_chk(4'hc, 16'h0004);
    for (int i = 0; i < 10; i++) rd_chk(4'hf, 16'h0100 + i[15:0]);
    tick(1); rd_chk(4'hc, 16'h0000);
    // Clear status
    wr_reg(4'hb, 16'h0001);
    @(negedge clk) begin eqp = 1; sc = 16'h0001; end
    @(negedge clk) eqp = 0;
    tick(1); rd_chk(4'h3, 16'h0001);
    rd_chk(4'hc, 16'h0024);
    tick(2); @(negedge clk) cs = 1; @(negedge clk) cs = 0;
    tick(1); rd_chk(4'h7, 16'h0000);
    rd_chk(4'hc, 16'h0000);
    stop_test();
  end
endmodule
